// >>> src/cspr_pkg.sv
package cspr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h09;
  localparam logic [7:0] FAULT_OFS = 8'h0a;
  localparam logic [7:0] CLASH_OFS = 8'h0b;
  localparam logic [7:0] TIMER_OFS = 8'h0c;
  localparam logic [7:0] CHECK_OFS = 8'h0d;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FAULT_RST = 8'h40;
  localparam logic [7:0] CLASH_RST = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IDLE_BIT = 5;
  localparam int SLEEP_BIT = 4;
  localparam int CIPHER_BIT = 3;
  localparam int HALT_BIT = 2;
  localparam int LAUNCH_BIT = 1;
  localparam int CLEAR_BIT = 0;

  localparam int KEY_BIT = 6;
  localparam int PERM_BIT = 5;
  localparam int OVR_BIT = 4;
  localparam int SUM_BIT = 3;
  localparam int SOF_BIT = 2;
  localparam int PAR_BIT = 1;
  localparam int CLASH_BIT = 0;

  // Events reported by the receiver, command engine and FIFO
  typedef struct packed {
    logic auth2_ok;
    logic cipher_off;
    logic key_cmd_start;
    logic key_fmt_bad;
    logic nv_cmd_start;
    logic nv_perm_bad;
    logic fifo_wr_full;
    logic rx_prepare;
    logic rx_crc_bad;
    logic rx_sof_bad;
    logic rx_par_bad;
    logic rx_clash;
    logic [7:0] clash_pos;
  } cspr_evt_t;

  // Controls toward the rest of the reader
  typedef struct packed {
    logic standby;
    logic power_down;
    logic cipher_on;
    logic timer_stop;
    logic timer_start;
    logic fifo_flush;
  } cspr_ctl_t;

endpackage : cspr_pkg

// >>> src/cspr_regs.sv
// Notes on behaviour
// - Control register at 09h, reset 00h, bits 7 and 6 reserved.
// - Writing bit 5 requests standby; clock keeps running.
// - Writing bit 4 requests power-down; clock stops too.
// - cipher_active 1 encrypts card traffic, 0 leaves it plain.
// - cipher_active set only by successful second_auth_step, never by host.
// - Writing bit 2 stops the timer at once.
// - Writing bit 1 starts the timer at once.
// - Writing bit 0 flushes FIFO pointers, fill count and overrun flag.
// - The three strobe bits always read as 0.
// - Read-only fault register at 0Ah, reset 40h, last command status.
// - key_format_fault cleared at key-load start, set on bad key format.
// - nv_permission_fault cleared at memory command start, set on violation.
// - queue_overrun_flag set on any write into a full FIFO.
// - check_sum_fault set when rx_check_enable and received CRC fails.
// - start_of_frame_fault set on incorrect start-of-frame.
// - odd_even_fault set on receive parity failure.
// - bit_clash_flag set on detected bit collision.
// - Four receive faults cleared in rx_prepare_state at receiver start.
// - first_clash_index at 0Bh, reset 00h, first collision position.
// - countdown_reading at 0Ch returns current timer value.
// - check_low_byte at 0Dh gives CRC low byte, valid when check_done.
// - check_done reads 1 when CRC finished, 0 while ongoing.
`timescale 1ns/1ns
`default_nettype none
module cspr_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic rx_check_enable,
  input wire logic [7:0] timer_count,
  input wire logic [7:0] crc_low,
  input wire logic crc_busy,
  input wire cspr_pkg::cspr_evt_t evt,
  output cspr_pkg::cspr_ctl_t ctl,
  output logic check_done
);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic standby_q, standby_d;
  logic sleep_q, sleep_d;
  logic cipher_q, cipher_d;
  logic halt_q, halt_d;
  logic launch_q, launch_d;
  logic flush_q, flush_d;
  logic ctrl_wr;

  always_comb
  begin
    ctrl_wr = wr_en && (addr == cspr_pkg::CTRL_OFS);
    standby_d = standby_q;
    sleep_d = sleep_q;
    cipher_d = cipher_q;
    if (ctrl_wr)
    begin
      standby_d = wdata[cspr_pkg::IDLE_BIT];
      sleep_d = wdata[cspr_pkg::SLEEP_BIT];
      // Host may drop the cipher but never raise it
      if (!wdata[cspr_pkg::CIPHER_BIT])
        cipher_d = 1'b0;
    end
    if (evt.cipher_off)
      cipher_d = 1'b0;
    if (evt.auth2_ok)
      cipher_d = 1'b1;
    halt_d = ctrl_wr && wdata[cspr_pkg::HALT_BIT];
    launch_d = ctrl_wr && wdata[cspr_pkg::LAUNCH_BIT];
    flush_d = ctrl_wr && wdata[cspr_pkg::CLEAR_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      standby_q <= cspr_pkg::CTRL_RST[cspr_pkg::IDLE_BIT];
      sleep_q <= cspr_pkg::CTRL_RST[cspr_pkg::SLEEP_BIT];
      cipher_q <= cspr_pkg::CTRL_RST[cspr_pkg::CIPHER_BIT];
      halt_q <= 1'b0;
      launch_q <= 1'b0;
      flush_q <= 1'b0;
    end
    else
    begin
      standby_q <= standby_d;
      sleep_q <= sleep_d;
      cipher_q <= cipher_d;
      halt_q <= halt_d;
      launch_q <= launch_d;
      flush_q <= flush_d;
    end
  end

  assign ctl.standby = standby_q;
  assign ctl.power_down = sleep_q;
  assign ctl.cipher_on = cipher_q;
  assign ctl.timer_stop = halt_q;
  assign ctl.timer_start = launch_q;
  assign ctl.fifo_flush = flush_q;

  // ----------------------------------------
  // Fault flags and collision position
  // ----------------------------------------
  // Hardware events win over clears issued in the same cycle
  logic [7:0] fault_q, fault_d;
  logic [7:0] clash_q, clash_d;

  always_comb
  begin
    fault_d = fault_q;
    clash_d = clash_q;
    if (evt.key_cmd_start)
      fault_d[cspr_pkg::KEY_BIT] = 1'b0;
    if (evt.key_fmt_bad)
      fault_d[cspr_pkg::KEY_BIT] = 1'b1;
    if (evt.nv_cmd_start)
      fault_d[cspr_pkg::PERM_BIT] = 1'b0;
    if (evt.nv_perm_bad)
      fault_d[cspr_pkg::PERM_BIT] = 1'b1;
    if (flush_q)
      fault_d[cspr_pkg::OVR_BIT] = 1'b0;
    if (evt.fifo_wr_full)
      fault_d[cspr_pkg::OVR_BIT] = 1'b1;
    if (evt.rx_prepare)
    begin
      fault_d[cspr_pkg::SUM_BIT] = 1'b0;
      fault_d[cspr_pkg::SOF_BIT] = 1'b0;
      fault_d[cspr_pkg::PAR_BIT] = 1'b0;
      fault_d[cspr_pkg::CLASH_BIT] = 1'b0;
    end
    if (evt.rx_crc_bad && rx_check_enable)
      fault_d[cspr_pkg::SUM_BIT] = 1'b1;
    if (evt.rx_sof_bad)
      fault_d[cspr_pkg::SOF_BIT] = 1'b1;
    if (evt.rx_par_bad)
      fault_d[cspr_pkg::PAR_BIT] = 1'b1;
    // Only the first collision of a frame is recorded
    if (evt.rx_clash)
    begin
      fault_d[cspr_pkg::CLASH_BIT] = 1'b1;
      if (!fault_q[cspr_pkg::CLASH_BIT] || evt.rx_prepare)
        clash_d = evt.clash_pos;
    end
    fault_d[7] = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fault_q <= cspr_pkg::FAULT_RST;
      clash_q <= cspr_pkg::CLASH_RST;
    end
    else
    begin
      fault_q <= fault_d;
      clash_q <= clash_d;
    end
  end

  // ----------------------------------------
  // Read port and CRC status
  // ----------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic done_q, done_d;

  always_comb
  begin
    done_d = !crc_busy;
    rdata_d = rdata_q;
    if (rd_en)
    begin
      unique case (addr)
        cspr_pkg::CTRL_OFS: rdata_d = {2'h0, standby_q, sleep_q, cipher_q, 3'h0};
        cspr_pkg::FAULT_OFS: rdata_d = fault_q;
        cspr_pkg::CLASH_OFS: rdata_d = clash_q;
        cspr_pkg::TIMER_OFS: rdata_d = timer_count;
        cspr_pkg::CHECK_OFS: rdata_d = crc_low;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
      done_q <= 1'b1;
    end
    else
    begin
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  assign rdata = rdata_q;
  assign check_done = done_q;

endmodule : cspr_regs
`default_nettype wire

// >>> tb/cspr_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cspr_regs_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] crc_low,
  input wire logic crc_busy,
  input wire cspr_pkg::cspr_evt_t evt,
  input wire cspr_pkg::cspr_ctl_t ctl,
  input wire logic check_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence ctl_wr; wr_en && addr == 8'h09; endsequence
  sequence ctl_rd; rd_en && addr == 8'h09; endsequence
  flush_pulse_a: assert property (ctl_wr |=> ctl.fifo_flush == $past(wdata[0]))
    else $error("flush strobe wrong");
  launch_pulse_a: assert property (ctl_wr |=> ctl.timer_start == $past(wdata[1]))
    else $error("start strobe wrong");
  halt_pulse_a: assert property (ctl_wr |=> ctl.timer_stop == $past(wdata[2]))
    else $error("stop strobe wrong");
  power_level_a: assert property (ctl_wr |=> ctl.standby == $past(wdata[5]))
    else $error("standby level wrong");
  cipher_set_a: assert property ($rose(ctl.cipher_on) |-> $past(evt.auth2_ok))
    else $error("cipher set without auth");
  done_busy_a: assert property (crc_busy |=> !check_done)
    else $error("done while busy");
  crc_read_a: assert property (rd_en && addr == 8'h0d && !crc_busy |=> rdata == $past(crc_low))
    else $error("crc byte wrong");
  strobe_zero_a: assert property (ctl_rd |=> rdata[2:0] == 3'h0 && rdata[7:6] == 2'h0)
    else $error("strobe bits read back");
endmodule : cspr_regs_sva
bind cspr_regs cspr_regs_sva u_sva (.clk, .rst, .addr, .wr_en, .rd_en, .wdata, .rdata,
  .crc_low, .crc_busy, .evt, .ctl, .check_done);
`default_nettype wire

// >>> tb/cspr_host.sv
`timescale 1ns/1ns
`default_nettype none
module cspr_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wdata
);
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'h0;
    rd_en = 1'h0;
  end
  // Idle address lines, and data lines after a write, are inverted so stale values never pass as a request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'h1;
    @(negedge clk);
    wr_en = 1'h0;
    addr = ~a;
    wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'h1;
    @(negedge clk);
    rd_en = 1'h0;
    addr = ~a;
    d = rdata;
  endtask : rd
endmodule : cspr_host
`default_nettype wire

// >>> tb/cspr_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module cspr_regs_test;
  logic clk, rst, wr_en, rd_en, rx_check_enable, crc_busy, check_done, cip, sbm, pdm, arm;
  logic [7:0] addr, wdata, rdata, timer_count, crc_low, pos, rv, e, a, d;
  logic [6:0] flt;
  cspr_pkg::cspr_evt_t evt;
  cspr_pkg::cspr_ctl_t ctl;
  int err_count, num_checks, cyc;
  cspr_regs u_cspr_regs (.clk, .rst, .addr, .wr_en, .rd_en, .wdata, .rdata, .rx_check_enable,
    .timer_count, .crc_low, .crc_busy, .evt, .ctl, .check_done);
  cspr_host u_cspr_host (.clk, .rdata, .addr, .wr_en, .rd_en, .wdata);
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic pulse(input logic [19:0] v);
    @(negedge clk);
    evt = v;
    @(negedge clk);
    evt = 20'h00000;
    flt = flt & ~{v[17], v[15], 1'h0, {4{v[12]}}};
    flt = flt | {v[16], v[14:13], v[11] & rx_check_enable, v[10:8]};
    cip = v[19] | cip & ~v[18];
    arm = arm | v[12];
    if (arm && v[8])
    begin
      pos = v[7:0];
      arm = 1'h0;
    end
  endtask : pulse
  task automatic check_all();
    for (int i = 9; i < 15; i++)
    begin
      u_cspr_host.rd(8'(i), rv);
      case (i)
        9: e = {2'h0, sbm, pdm, cip, 3'h0};
        10: e = {1'h0, flt};
        11: e = pos;
        12: e = timer_count;
        13: e = crc_low;
        default: e = 8'h00;
      endcase
      // The low byte is undefined while a calculation runs
      if (i != 13 || !crc_busy) check(rv, e);
    end
    check({7'h00, check_done}, {7'h00, ~crc_busy});
  endtask : check_all
  initial
  begin
    rst = 1'h1;
    evt = 20'h00000;
    {rx_check_enable, crc_busy, cip, sbm, pdm, arm} = 6'h00;
    {timer_count, crc_low, pos} = 24'h000000;
    flt = 7'h40;
    rv = 8'($urandom(54));
    repeat (6) @(negedge clk);
    rst = 1'h0;
    check({2'h0, ctl}, 8'h00);
    check_all();
    $display("test reset_values done");
    pulse(20'h01000);
    repeat (60)
    begin
      rx_check_enable = 1'($urandom);
      crc_busy = 1'($urandom);
      timer_count = 8'($urandom);
      crc_low = 8'($urandom);
      pulse(20'($urandom & $urandom & $urandom));
      a = 8'h09 + 8'($urandom % 6);
      d = 8'($urandom);
      u_cspr_host.wr(a, d);
      if (a == 8'h09)
      begin
        sbm = d[5];
        pdm = d[4];
        cip = cip & d[3];
        flt[4] = flt[4] & ~d[0];
      end
      e = {2'h0, sbm, pdm, cip, (a == 8'h09) ? d[2:0] : 3'h0};
      check({2'h0, ctl}, e);
      check_all();
    end
    $display("test random_traffic done");
    report_and_stop();
  end
endmodule : cspr_regs_test
`default_nettype wire
